// ---- logic/acsc_top.sv ----
// conversion-start, power-down and output-enable control
// Functional notes
// - Output bus driven only while chip select and read are both low.
// - Chip select gates the external serial clock; edges ignored while high.
// - Reset high resets logic and aborts conversion, dropping its result.
// - Power-down lets current conversion finish, then blocks new ones.
// - Start high at acquisition end: wait for falling edge, then convert.
// - Start already low at acquisition end: convert at once.
// - Busy high from conversion start until result latched into shift register.
// - Unfinished external-clock serial read at completion: discard, pulse error flag.
module acsc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire acsc_pkg::acsc_ctrl_s ctrl,
  input wire logic [acsc_pkg::ACSC_DATA_W-1:0] conv_result,
  output logic busy,
  output logic sample_hold,
  output logic powered_down,
  output logic [acsc_pkg::ACSC_DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic sdout,
  output logic incomplete_read_flag
);
  import acsc_pkg::*;

  acsc_ctrl_s sync_q;
  acsc_state_e state_r;
  acsc_state_e state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic start_d_r;
  logic sclk_d_r;
  logic [ACSC_DATA_W-1:0] shift_r;
  logic [4:0] bits_r;
  logic read_busy_r;

  // every pin input crosses two flops
  acsc_sync #(.W($bits(acsc_ctrl_s)), .RST_VAL(ACSC_CTRL_IDLE)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .d(ctrl),
    .q(sync_q)
  );

  // decoded conditions
  wire dev_reset = sync_q.reset;
  wire start_low = !sync_q.conversion_start_n;
  wire start_fall = start_d_r && !sync_q.conversion_start_n;
  wire cnt_done = (cnt_r == 8'h00);
  wire bus_enable = !sync_q.cs_n && !sync_q.rd_n;
  wire ext_clk_mode = sync_q.serial_mode && sync_q.serial_clock_source_select;
  wire sclk_gated = sync_q.sclk && !sync_q.cs_n;
  wire sclk_rise = sclk_gated && !sclk_d_r;
  wire conv_finish = (state_r == ACSC_CONV) && cnt_done;
  wire read_open = read_busy_r && (bits_r != 5'h00);
  wire rd_error = conv_finish && ext_clk_mode && read_open;

  // conversion sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? 8'h00 : cnt_r - 8'h01;
    case (state_r)
      ACSC_ACQ:
      begin
        if (cnt_done)
        begin
          if (sync_q.power_down_request)
            state_nxt = ACSC_IDLE_PD;
          else if (start_low)
            state_nxt = ACSC_ARMED;
          else
            state_nxt = ACSC_WAIT_EDGE;
        end
      end
      ACSC_WAIT_EDGE:
      begin
        if (sync_q.power_down_request)
          state_nxt = ACSC_IDLE_PD;
        else if (start_fall)
          state_nxt = ACSC_ARMED;
      end
      ACSC_ARMED:
      begin
        state_nxt = ACSC_CONV;
        cnt_nxt = ACSC_CONV_CYCLES;
      end
      ACSC_CONV:
      begin
        if (cnt_done)
        begin
          state_nxt = ACSC_ACQ;
          cnt_nxt = ACSC_ACQ_CYCLES;
        end
      end
      ACSC_IDLE_PD:
      begin
        if (!sync_q.power_down_request)
        begin
          state_nxt = ACSC_ACQ;
          cnt_nxt = ACSC_ACQ_CYCLES;
        end
      end
      default:
      begin
        state_nxt = ACSC_ACQ;
        cnt_nxt = ACSC_ACQ_CYCLES;
      end
    endcase
  end

  // state registers; device reset pin aborts like the system reset
  always_ff @(posedge clk)
  begin
    if (!reset_n || (ce && dev_reset))
    begin
      state_r <= ACSC_ACQ;
      cnt_r <= ACSC_ACQ_CYCLES;
      busy <= 1'b0;
      sample_hold <= 1'b0;
      powered_down <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy <= (state_nxt == ACSC_CONV);
      sample_hold <= (state_nxt == ACSC_CONV);
      powered_down <= (state_nxt == ACSC_IDLE_PD);
    end
  end

  // edge history for start strobe and raw serial clock; a chip-select fall is no clock edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      start_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end
    else if (ce)
    begin
      start_d_r <= sync_q.conversion_start_n;
      sclk_d_r <= sync_q.sclk;
    end
  end

  // result shift register, loaded when a conversion ends
  always_ff @(posedge clk)
  begin
    if (!reset_n || (ce && dev_reset))
    begin
      shift_r <= '0;
      bits_r <= 5'h00;
      read_busy_r <= 1'b0;
    end
    else if (ce)
    begin
      if (conv_finish)
      begin
        shift_r <= conv_result;
        bits_r <= ACSC_BIT_COUNT;
        read_busy_r <= 1'b0;
      end
      else if (ext_clk_mode && bus_enable && sclk_rise && bits_r != 5'h00)
      begin
        shift_r <= {shift_r[ACSC_DATA_W-2:0], 1'b0};
        bits_r <= bits_r - 5'h01;
        read_busy_r <= 1'b1;
      end
    end
  end

  // pin outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_out <= '0;
      data_oe_n <= 1'b1;
      sdout <= 1'b0;
      incomplete_read_flag <= 1'b0;
    end
    else if (ce)
    begin
      data_out <= sync_q.serial_mode ? '0 : shift_r;
      data_oe_n <= !bus_enable;
      sdout <= sync_q.serial_mode && bus_enable && shift_r[ACSC_DATA_W-1];
      incomplete_read_flag <= rd_error && !dev_reset;
    end
  end

  sequence s_conv_begin;
    ce && (state_r == ACSC_ARMED) && !dev_reset;
  endsequence

  a_busy_on_start: assert property (@(posedge clk) disable iff (!reset_n)
    s_conv_begin |=> busy)
    else $error("busy not raised at conversion start");

  a_busy_low_idle: assert property (@(posedge clk) disable iff (!reset_n)
    ce && state_r == ACSC_ACQ |=> !busy || !ce)
    else $error("busy high outside conversion");

  a_oe_gated: assert property (@(posedge clk) disable iff (!reset_n)
    ce |=> data_oe_n == !$past(bus_enable))
    else $error("bus enabled without cs and rd low");

  a_reset_aborts: assert property (@(posedge clk) disable iff (!reset_n)
    ce && dev_reset |=> state_r == ACSC_ACQ && !busy)
    else $error("reset did not abort conversion");

  a_pd_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ACSC_IDLE_PD && sync_q.power_down_request |=> state_r != ACSC_CONV)
    else $error("conversion started in power-down");

  a_edge_start: assert property (@(posedge clk) disable iff (!reset_n)
    ce && state_r == ACSC_WAIT_EDGE && !start_fall |=> state_r != ACSC_ARMED)
    else $error("conversion started without falling edge");

  a_low_start: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !dev_reset && state_r == ACSC_ACQ && cnt_done && start_low
      && !sync_q.power_down_request |=> state_r == ACSC_ARMED)
    else $error("low start did not convert at once");

  a_rderr_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    incomplete_read_flag |-> $past(conv_finish) && $past(ext_clk_mode))
    else $error("error flag without unfinished read");

  a_after_reset: assert property (@(posedge clk)
    !reset_n |=> state_r == ACSC_ACQ && !busy)
    else $error("reset did not start in acquisition");
endmodule : acsc_top

// ---- logic/acsc_pkg.sv ----
// package for the conversion-start control block
package acsc_pkg;
  localparam int ACSC_DATA_W = 16;
  // conversion phase length in cycles (plain default, internal clock)
  localparam logic [7:0] ACSC_CONV_CYCLES = 8'h28;
  // acquisition phase length in cycles
  localparam logic [7:0] ACSC_ACQ_CYCLES = 8'h0A;
  localparam logic [4:0] ACSC_BIT_COUNT = 5'h10;
  // idle pin levels held by the synchronisers in reset: active-low strobes high, rest low
  localparam logic [7:0] ACSC_CTRL_IDLE = 8'hE0;

  typedef enum logic [4:0] {
    ACSC_ACQ = 5'h01,
    ACSC_WAIT_EDGE = 5'h02,
    ACSC_CONV = 5'h04,
    ACSC_IDLE_PD = 5'h08,
    ACSC_ARMED = 5'h10
  } acsc_state_e;

  // host control strobes, as seen at the pins
  typedef struct packed {
    logic conversion_start_n;
    logic cs_n;
    logic rd_n;
    logic reset;
    logic power_down_request;
    logic serial_mode;
    logic serial_clock_source_select;
    logic sclk;
  } acsc_ctrl_s;
endpackage : acsc_pkg

// ---- logic/acsc_sync.sv ----
// two-flop synchroniser bank for pin inputs
module acsc_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_r <= RST_VAL; // idle levels, so no false enable or edge after reset
      q <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : acsc_sync

// ---- sim/acsc_host_model.sv ----
// host controller model that drives the control strobes
module acsc_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic hold_low,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic abort,
  input wire logic pd,
  input wire logic ser,
  input wire logic ext,
  input wire logic sclk,
  output acsc_pkg::acsc_ctrl_s ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  import acsc_pkg::*;
  logic [2:0] low_cnt_r = 3'h0;
  // one short low pulse per request gives a clean falling edge
  always @(posedge clk)
  begin
    if (go)
      low_cnt_r <= 3'h4;
    else if (low_cnt_r != 3'h0)
      low_cnt_r <= low_cnt_r - 3'h1;
  end
  // mode pins and serial clock pass straight through; the bench moves the clock only in the serial test
  assign ctrl = '{conversion_start_n: !(hold_low || low_cnt_r != 3'h0), cs_n: cs_n, rd_n: rd_n,
    reset: abort, power_down_request: pd, serial_mode: ser, serial_clock_source_select: ext, sclk: sclk};
endmodule : acsc_host_model

// ---- sim/acsc_top_tb.sv ----
// self-checking bench for the conversion-start control block
module acsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acsc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic hold_low = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic abort = 1'b0;
  logic pd = 1'b0;
  logic ce = 1'b1;
  logic ser = 1'b0;
  logic ext = 1'b0;
  logic sclk = 1'b0;
  logic sdout;
  logic incomplete_read_flag;
  logic busy, sample_hold, powered_down, data_oe_n;
  logic [ACSC_DATA_W-1:0] data_out;
  logic [ACSC_DATA_W-1:0] result_val = 16'hA5C3;
  acsc_ctrl_s ctrl;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  always #2.5 clk = ~clk;
  acsc_host_model acsc_host_model_i (.clk(clk), .go(go), .hold_low(hold_low), .cs_n(cs_n), .rd_n(rd_n),
    .abort(abort), .pd(pd), .ser(ser), .ext(ext), .sclk(sclk), .ctrl(ctrl));
  acsc_top acsc_top_i (.clk(clk), .reset_n(reset_n), .ce(ce), .ctrl(ctrl), .conv_result(result_val),
    .busy(busy), .sample_hold(sample_hold), .powered_down(powered_down), .data_out(data_out),
    .data_oe_n(data_oe_n), .sdout(sdout), .incomplete_read_flag(incomplete_read_flag));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (busy !== lvl && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_busy
  task automatic start_edge();
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    #1;
  endtask : start_edge
  task automatic t_start();
    cyc(15);
    chk("idle busy", busy, 1'b0);
    start_edge();
    wait_busy(1'b1, 10);
    chk("busy", busy, 1'b1);
    chk("hold", sample_hold, 1'b1);
    cyc(30);
    chk("busy held", busy, 1'b1);
    wait_busy(1'b0, 20);
    chk("busy end", busy, 1'b0);
    cyc(20);
    chk("no restart", busy, 1'b0);
  endtask : t_start
  task automatic t_hold_low();
    @(posedge clk) hold_low <= 1'b1;
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 50);
    wait_busy(1'b1, 20);
    chk("restart", busy, 1'b1);
    @(posedge clk) hold_low <= 1'b0;
    wait_busy(1'b0, 50);
  endtask : t_hold_low
  task automatic t_read();
    @(posedge clk) cs_n <= 1'b0;
    cyc(6);
    chk("oe cs only", data_oe_n, 1'b1);
    @(posedge clk) rd_n <= 1'b0;
    cyc(6);
    chk("oe", data_oe_n, 1'b0);
    chk("data", data_out, result_val);
    @(posedge clk) rd_n <= 1'b1;
    cyc(6);
    chk("oe off", data_oe_n, 1'b1);
    @(posedge clk) cs_n <= 1'b1;
  endtask : t_read
  task automatic t_abort();
    cyc(15);
    start_edge();
    wait_busy(1'b1, 10);
    @(posedge clk) abort <= 1'b1;
    wait_busy(1'b0, 6);
    chk("abort", busy, 1'b0);
    cyc(1);
    chk("abort data", data_out, 16'h0000);
    @(posedge clk) abort <= 1'b0;
    cyc(20);
  endtask : t_abort
  task automatic t_pd();
    start_edge();
    wait_busy(1'b1, 10);
    @(posedge clk) pd <= 1'b1;
    cyc(10);
    chk("pd finish", busy, 1'b1);
    wait_busy(1'b0, 45);
    cyc(15);
    chk("pd state", powered_down, 1'b1);
    start_edge();
    cyc(20);
    chk("pd refuse", busy, 1'b0);
    @(posedge clk) pd <= 1'b0;
    cyc(20);
    chk("pd exit", powered_down, 1'b0);
    start_edge();
    wait_busy(1'b1, 10);
    chk("pd wake", busy, 1'b1);
  endtask : t_pd
  // low clock enable must stretch a running conversion
  task automatic t_freeze();
    start_edge();
    wait_busy(1'b1, 10);
    @(posedge clk) ce <= 1'b0;
    cyc(50);
    chk("frozen busy", busy, 1'b1);
    @(posedge clk) ce <= 1'b1;
    wait_busy(1'b0, 45);
    chk("thawed busy", busy, 1'b0);
    cyc(20);
  endtask : t_freeze
  // external-clock serial read: gating, bit order and the unfinished-read pulse
  task automatic t_serial();
    @(posedge clk);
    ser <= 1'b1;
    ext <= 1'b1;
    rd_n <= 1'b0;
    wait_busy(1'b0, 50);
    chk("no read flag", incomplete_read_flag, 1'b0);
    @(posedge clk) sclk <= 1'b1;
    cyc(4);
    @(posedge clk) cs_n <= 1'b0;
    cyc(4);
    @(posedge clk) sclk <= 1'b0;
    cyc(4);
    chk("gated sclk", sdout, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      chk("sdout bit", sdout, result_val[15-i]);
      @(posedge clk) sclk <= 1'b1;
      cyc(4);
      @(posedge clk) sclk <= 1'b0;
      cyc(4);
    end
    start_edge();
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 50);
    chk("read flag", incomplete_read_flag, 1'b1);
    cyc(1);
    chk("flag pulse", incomplete_read_flag, 1'b0);
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    ser <= 1'b0;
    ext <= 1'b0;
    cyc(4);
    chk("serial off", sdout, 1'b0);
  endtask : t_serial
  task automatic results();
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // watchdog sized well beyond the roughly seven hundred cycles of the run
  initial
  begin
    cyc(3000);
    error_cnt++;
    results();
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk("reset oe", data_oe_n, 1'b1);
    chk("reset busy", busy, 1'b0);
    t_start();
    t_hold_low();
    t_read();
    t_abort();
    t_freeze();
    t_pd();
    t_serial();
    results();
  end
endmodule : acsc_top_tb
